// >>> src/pwr_mode_map.vh
// constants and register map of the power mode clock switch
`ifndef PWR_MODE_MAP_VH
`define PWR_MODE_MAP_VH
// register byte addresses
`define ADDR_OSC_CTRL 4'h0
`define ADDR_SEC_CTRL 4'h4
`define ADDR_MODE_STAT 4'h8
`define ADDR_START_CFG 4'hc
// oscillator control fields
`define OSC_GATE_BIT 7
`define OSC_IRC_HI 6
`define OSC_IRC_LO 4
`define OSC_PRI_FLAG_BIT 3
`define OSC_INT_FLAG_BIT 2
`define OSC_SEL_HI 1
`define OSC_SEL_LO 0
// secondary control fields
`define SEC_FLAG_BIT 6
`define SEC_ENABLE_BIT 3
// status fields
`define STAT_MODE_HI 2
`define STAT_MODE_LO 0
`define STAT_STATE_HI 6
`define STAT_STATE_LO 4
// start-up configuration fields
`define CFG_TWO_SPEED_BIT 0
`define CFG_FAIL_SAFE_BIT 1
`define CFG_INT_PRIMARY_BIT 2
// reset values
`define GATE_RESET 1'h0
`define SEL_RESET 2'h0
`define IRC_RESET 3'h0
// clock sources
`define SRC_NONE 2'h0
`define SRC_PRI 2'h1
`define SRC_SEC 2'h2
`define SRC_INT 2'h3
// mode codes {idle, source minus one}; sleep has its own
`define MODE_PRIMARY_RUN_MODE 3'h0
`define MODE_SECONDARY_RUN_MODE 3'h1
`define MODE_INT_RUN 3'h2
`define MODE_PRIMARY_IDLE_MODE 3'h4
`define MODE_SECONDARY_IDLE_MODE 3'h5
`define MODE_INT_IDLE 3'h6
`define MODE_SLEEP 3'h7
// timing
`define SWITCH_TICKS 8
`define CLK_PERIOD_NS 50
`define WAKE_DELAY_NS 10000
`endif

// >>> src/sync_stage.v
// two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module sync_stage #(
   parameter WIDTH = 7
) (
   input wire clk_i,
   input wire sys_rst_i,
   input wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);
   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] stab_q;
   genvar g;
   // one two-stage chain per bit; first stage feeds only the second
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         always @(posedge clk_i) begin
            if (sys_rst_i) begin
               meta_q[g] <= 1'b0;
               stab_q[g] <= 1'b0;
            end else begin
               meta_q[g] <= async_i[g];
               stab_q[g] <= meta_q[g];
            end
         end
      end
   endgenerate
   assign sync_o = stab_q;
endmodule // sync_stage

// >>> src/tick_counter.v
// counts ticks of the incoming clock source during a switch
`timescale 1ns/1ps
module tick_counter #(
   parameter COUNT = 8
) (
   input wire clk_i,
   input wire sys_rst_i,
   input wire start_i,
   input wire tick_i,
   output wire done_o
);
   reg [4:0] cnt_q;
   reg run_q;
   // restart wins over a tick in the same cycle
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         cnt_q <= 5'h00;
         run_q <= 1'b0;
      end else if (start_i) begin
         cnt_q <= 5'h00;
         run_q <= 1'b1;
      end else if (run_q && tick_i) begin
         cnt_q <= cnt_q + 5'h01;
         if (cnt_q == COUNT - 1)
            run_q <= 1'b0;
      end
   end
   assign done_o = run_q && tick_i && (cnt_q == COUNT - 1);
endmodule // tick_counter

// >>> src/power_mode_clock_switch.v
// power mode controller with glitch-free source switch and ahb-lite registers
//
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "pwr_mode_map.vh"
module power_mode_clock_switch #(
   parameter SWITCH_TICKS = `SWITCH_TICKS
) (
   input wire clk_i,
   input wire sys_rst_i,
   // ahb-lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output wire [31:0] hrdata,
   // cpu core side, same clock
   input wire sleep_i,
   // oscillators and wake sources, asynchronous
   input wire pri_tick_i,
   input wire sec_tick_i,
   input wire int_tick_i,
   input wire pri_ready_i,
   input wire int_stable_i,
   input wire irq_pending_i,
   input wire wdt_timeout_i,
   // clock gating and oscillator control
   output wire cpu_clk_en_o,
   output wire periph_clk_en_o,
   output wire [1:0] sys_clk_src_o,
   output wire pri_osc_en_o,
   output wire cpu_ready_o,
   output wire wdt_reset_o
);
   localparam ST_RUN = 3'h0;
   localparam ST_SWITCH = 3'h1;
   localparam ST_PARK = 3'h2;
   localparam ST_WAKE = 3'h3;
   localparam ST_BACK = 3'h4;
   // wake delay in system clock cycles, rounded up
   localparam integer WAKE_CYCLES_N =
      (`WAKE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam [7:0] WAKE_CYCLES = WAKE_CYCLES_N[7:0];

   // software registers
   reg gate_q;
   reg [2:0] irc_q;
   reg [1:0] sel_q;
   reg sec_en_q;
   reg two_speed_q;
   reg fail_safe_q;
   reg int_primary_q;
   // mode machine
   reg [2:0] state_q;
   reg [2:0] after_q;
   reg [2:0] mode_q;
   reg [1:0] src_q;
   reg [1:0] tgt_q;
   reg pri_on_q;
   reg [7:0] wake_cnt_q;
   reg wdt_rst_q;
   reg sw_start_q;
   // ahb data phase
   reg dp_valid_q;
   reg dp_write_q;
   reg [3:0] dp_addr_q;
   // synchronised pins and edges
   reg [2:0] tick_last_q;
   wire [6:0] pin_sync;
   wire [2:0] tick_edge;
   wire ready_s;
   wire stable_s;
   wire irq_s;
   wire wdt_s;
   wire wdt_edge;
   reg wdt_last_q;
   wire sw_done;
   reg new_tick;
   // decode of a sleep request
   reg [1:0] req_src;
   reg [2:0] req_mode;
   reg req_ignore;
   wire wake_ev;
   wire irc_fast;
   wire pri_flag;
   wire int_flag;
   wire sec_flag;
   wire switching;
   reg [31:0] rd_mux;

   // all oscillator and wake pins cross into the system clock here
   sync_stage #(
      .WIDTH(7)
   ) u_sync (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i({wdt_timeout_i, irq_pending_i, int_stable_i, pri_ready_i,
         int_tick_i, sec_tick_i, pri_tick_i}),
      .sync_o(pin_sync)
   );
   assign ready_s = pin_sync[3];
   assign stable_s = pin_sync[4];
   assign irq_s = pin_sync[5];
   assign wdt_s = pin_sync[6];

   // rising edges of each source stand for one period of it
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         tick_last_q <= 3'h0;
         wdt_last_q <= 1'b0;
      end else begin
         tick_last_q <= pin_sync[2:0];
         wdt_last_q <= wdt_s;
      end
   end
   assign tick_edge = pin_sync[2:0] & ~tick_last_q;
   assign wdt_edge = wdt_s & ~wdt_last_q;
   assign wake_ev = irq_s || wdt_edge;

   // tick of the source being switched to
   always @* begin
      case (tgt_q)
         `SRC_PRI: new_tick = tick_edge[0];
         `SRC_SEC: new_tick = tick_edge[1];
         `SRC_INT: new_tick = tick_edge[2];
         default: new_tick = 1'b0;
      endcase
   end

   tick_counter #(
      .COUNT(SWITCH_TICKS)
   ) u_count (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(sw_start_q),
      .tick_i(new_tick),
      .done_o(sw_done)
   );

   // decode gate and select as they stand when sleep executes
   always @* begin
      req_ignore = 1'b0;
      case (sel_q)
         2'h0: req_src = `SRC_PRI;
         2'h1: req_src = `SRC_SEC;
         default: req_src = `SRC_INT;
      endcase
      req_mode = {gate_q, 2'h0} | {1'b0, req_src - 2'h1};
      if (!gate_q && sel_q == 2'h0) begin
         req_mode = `MODE_SLEEP;
         req_src = `SRC_NONE;
      end
      if (sel_q == 2'h1 && !sec_en_q)
         req_ignore = 1'b1;
   end

   // mode machine; gate and select are never written here
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_q <= ST_RUN;
         after_q <= ST_RUN;
         mode_q <= `MODE_PRIMARY_RUN_MODE;
         src_q <= `SRC_PRI;
         tgt_q <= `SRC_PRI;
         pri_on_q <= 1'b1;
         wake_cnt_q <= 8'h00;
         wdt_rst_q <= 1'b0;
         sw_start_q <= 1'b0;
      end else begin
         wdt_rst_q <= 1'b0;
         sw_start_q <= 1'b0;
         case (state_q)
            ST_RUN: begin
               if (wdt_edge) begin
                  wdt_rst_q <= 1'b1;
               end else if (sleep_i && !req_ignore) begin
                  mode_q <= req_mode;
                  tgt_q <= req_src;
                  if (req_src == `SRC_NONE) begin
                     src_q <= `SRC_NONE;
                     pri_on_q <= 1'b0;
                     state_q <= ST_PARK;
                  end else if (req_src != src_q) begin
                     sw_start_q <= 1'b1;
                     after_q <= req_mode[2] ? ST_PARK : ST_RUN;
                     state_q <= ST_SWITCH;
                  end else begin
                     state_q <= req_mode[2] ? ST_PARK : ST_RUN;
                  end
               end else if (irq_s && src_q != `SRC_PRI) begin
                  pri_on_q <= 1'b1;
                  state_q <= ST_BACK;
               end
            end
            ST_SWITCH: begin
               if (sw_done) begin
                  src_q <= tgt_q;
                  state_q <= after_q;
                  if (tgt_q != `SRC_PRI)
                     pri_on_q <= 1'b0; // primary idles only off its own source
               end
            end
            ST_PARK: begin
               if (wake_ev) begin
                  pri_on_q <= 1'b1;
                  wake_cnt_q <= 8'h00;
                  if (mode_q != `MODE_SLEEP) begin
                     mode_q <= {1'b0, mode_q[1:0]};
                     state_q <= ST_WAKE;
                  end else if (two_speed_q || fail_safe_q) begin
                     mode_q <= `MODE_INT_RUN;
                     tgt_q <= `SRC_INT;
                     sw_start_q <= 1'b1;
                     after_q <= ST_WAKE;
                     state_q <= ST_SWITCH;
                  end else begin
                     state_q <= ST_BACK;
                  end
               end
            end
            ST_WAKE: begin
               wake_cnt_q <= wake_cnt_q + 8'h01;
               if (wake_cnt_q == WAKE_CYCLES - 8'h01)
                  state_q <= (src_q == `SRC_PRI) ? ST_RUN : ST_BACK;
            end
            ST_BACK: begin
               pri_on_q <= 1'b1; // a fast start parks the primary, restart it here
               // a run mode here except after a sleep wake without fast start: a watchdog edge asks for reset
               if (wdt_edge) begin
                  wdt_rst_q <= 1'b1;
               end else if (ready_s) begin
                  mode_q <= `MODE_PRIMARY_RUN_MODE;
                  tgt_q <= `SRC_PRI;
                  sw_start_q <= 1'b1;
                  wake_cnt_q <= 8'h00;
                  after_q <= (src_q == `SRC_NONE) ? ST_WAKE : ST_RUN;
                  state_q <= ST_SWITCH;
               end
            end
            default: state_q <= ST_RUN;
         endcase
      end
   end

   // clock gates: nothing runs while the switch counts
   assign switching = (state_q == ST_SWITCH);
   assign periph_clk_en_o = !switching && (src_q != `SRC_NONE);
   assign cpu_clk_en_o = periph_clk_en_o &&
      (state_q == ST_RUN || state_q == ST_BACK);
   assign cpu_ready_o = cpu_clk_en_o;
   assign sys_clk_src_o = src_q;
   assign pri_osc_en_o = pri_on_q;
   assign wdt_reset_o = wdt_rst_q;

   // status flags follow the source actually driving the clock
   assign irc_fast = (irc_q != 3'h0);
   assign pri_flag = !switching && src_q == `SRC_PRI && ready_s;
   assign sec_flag = !switching && src_q == `SRC_SEC;
   assign int_flag = !switching && irc_fast && stable_s &&
      (src_q == `SRC_INT || (int_primary_q && src_q == `SRC_PRI));

   // ahb-lite address phase capture
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         dp_valid_q <= 1'b0;
         dp_write_q <= 1'b0;
         dp_addr_q <= 4'h0;
      end else if (hready) begin
         dp_valid_q <= hsel && htrans[1];
         dp_write_q <= hwrite;
         dp_addr_q <= haddr[3:0];
      end
   end

   // register writes in the data phase; select only stored
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         gate_q <= `GATE_RESET;
         irc_q <= `IRC_RESET;
         sel_q <= `SEL_RESET;
         sec_en_q <= 1'b0;
         two_speed_q <= 1'b0;
         fail_safe_q <= 1'b0;
         int_primary_q <= 1'b0;
      end else if (dp_valid_q && dp_write_q) begin
         case (dp_addr_q)
            `ADDR_OSC_CTRL: begin
               gate_q <= hwdata[`OSC_GATE_BIT];
               irc_q <= hwdata[`OSC_IRC_HI:`OSC_IRC_LO];
               sel_q <= hwdata[`OSC_SEL_HI:`OSC_SEL_LO];
            end
            `ADDR_SEC_CTRL: begin
               sec_en_q <= hwdata[`SEC_ENABLE_BIT];
            end
            `ADDR_START_CFG: begin
               two_speed_q <= hwdata[`CFG_TWO_SPEED_BIT];
               fail_safe_q <= hwdata[`CFG_FAIL_SAFE_BIT];
               int_primary_q <= hwdata[`CFG_INT_PRIMARY_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   // read mux; unmapped offsets read zero
   always @* begin
      rd_mux = 32'h0000_0000;
      case (dp_addr_q)
         `ADDR_OSC_CTRL: begin
            rd_mux[`OSC_GATE_BIT] = gate_q;
            rd_mux[`OSC_IRC_HI:`OSC_IRC_LO] = irc_q;
            rd_mux[`OSC_PRI_FLAG_BIT] = pri_flag;
            rd_mux[`OSC_INT_FLAG_BIT] = int_flag;
            rd_mux[`OSC_SEL_HI:`OSC_SEL_LO] = sel_q;
         end
         `ADDR_SEC_CTRL: begin
            rd_mux[`SEC_FLAG_BIT] = sec_flag;
            rd_mux[`SEC_ENABLE_BIT] = sec_en_q;
         end
         `ADDR_MODE_STAT: begin
            rd_mux[`STAT_MODE_HI:`STAT_MODE_LO] = mode_q;
            rd_mux[`STAT_STATE_HI:`STAT_STATE_LO] = state_q;
         end
         `ADDR_START_CFG: begin
            rd_mux[`CFG_TWO_SPEED_BIT] = two_speed_q;
            rd_mux[`CFG_FAIL_SAFE_BIT] = fail_safe_q;
            rd_mux[`CFG_INT_PRIMARY_BIT] = int_primary_q;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // zero wait states keep read-after-write coherent without forwarding
   assign hrdata = (dp_valid_q && !dp_write_q) ? rd_mux : 32'h0000_0000;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
endmodule // power_mode_clock_switch

// >>> dv/pmcs_asserts.sv
// port checker for the power mode clock switch
`timescale 1ns/1ps
module pmcs_asserts (
   input logic clk_i,
   input logic sys_rst_i,
   input logic hreadyout,
   input logic hresp,
   input logic irq_pending_i,
   input logic wdt_timeout_i,
   input logic cpu_clk_en_o,
   input logic periph_clk_en_o,
   input logic [1:0] sys_clk_src_o,
   input logic pri_osc_en_o,
   input logic cpu_ready_o,
   input logic wdt_reset_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // the bus never stalls and never errors
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not okay");
   chk_ready_gate: assert property (cpu_ready_o == cpu_clk_en_o)
      else $error("cpu ready differs from cpu gate");
   chk_run_both: assert property (cpu_clk_en_o |-> periph_clk_en_o)
      else $error("cpu clocked without peripherals");
   chk_sleep_all: assert property (sys_clk_src_o == 2'h0 |-> !cpu_clk_en_o && !periph_clk_en_o)
      else $error("clock running with no source");
   chk_pri_live: assert property (sys_clk_src_o == 2'h1 && periph_clk_en_o |-> pri_osc_en_o)
      else $error("primary in use while shut down");
   // a new source only takes over while the gates are closed
   chk_src_glitch: assert property ($changed(sys_clk_src_o) && sys_clk_src_o != 2'h0
      |-> $past(!periph_clk_en_o))
      else $error("source changed with gates open");
   chk_wdt_pulse: assert property (wdt_reset_o |-> cpu_clk_en_o && wdt_timeout_i ##1 !wdt_reset_o)
      else $error("watchdog reset not a run mode pulse");
   chk_irq_wake: assert property ($rose(irq_pending_i) ##1 irq_pending_i [*4]
      |-> ##[0:600] cpu_clk_en_o)
      else $error("interrupt did not restart the cpu");
endmodule // pmcs_asserts

bind power_mode_clock_switch pmcs_asserts i_chk (.clk_i, .sys_rst_i, .hreadyout, .hresp,
   .irq_pending_i, .wdt_timeout_i, .cpu_clk_en_o, .periph_clk_en_o, .sys_clk_src_o,
   .pri_osc_en_o, .cpu_ready_o, .wdt_reset_o);

// >>> dv/cpu_osc_model.sv
// oscillator sources and cpu core stand-in facing the power mode clock switch
`timescale 1ns/1ps
module cpu_osc_model (
   input logic clk_i,
   input logic pri_osc_en_i,
   input logic cpu_ready_i,
   input logic sleep_req_i,
   input logic irq_req_i,
   input logic wdt_req_i,
   output logic sleep_o,
   output logic pri_tick_o,
   output logic sec_tick_o,
   output logic int_tick_o,
   output logic pri_ready_o,
   output logic int_stable_o,
   output logic irq_o,
   output logic wdt_o
);
   logic req_q = 1'b0;
   int rdy_n = 0;
   initial {pri_tick_o, sec_tick_o, int_tick_o, sleep_o, pri_ready_o} = 5'h0;
   // sources run at periods unrelated to the system clock
   always #137 sec_tick_o = !sec_tick_o;
   always #119 int_tick_o = !int_tick_o;
   // primary stands still while shut down, so a switch to it cannot finish early
   always #163 pri_tick_o = pri_osc_en_i && !pri_tick_o;
   // ready needs 30 cycles of start-up and drops at once on shutdown
   always @(posedge clk_i) begin
      rdy_n <= pri_osc_en_i ? (rdy_n < 30 ? rdy_n + 1 : rdy_n) : 0;
      pri_ready_o <= pri_osc_en_i && rdy_n == 30;
      // a sleep instruction only executes while the core is clocked
      sleep_o <= sleep_req_i && !req_q && cpu_ready_i;
      req_q <= sleep_req_i;
   end
   assign irq_o = irq_req_i;
   assign wdt_o = wdt_req_i;
   assign int_stable_o = 1'b1;
endmodule // cpu_osc_model

// >>> dv/power_mode_clock_switch_tb.sv
// self-checking bench for the power mode clock switch
`timescale 1ns/1ps
module power_mode_clock_switch_tb;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic sleep_req = 1'b0;
   logic irq_req = 1'b0;
   logic wdt_req = 1'b0;
   logic wdt_seen = 1'b0;
   logic hreadyout, hresp, sleep_i, pri_tick_i, sec_tick_i, int_tick_i, pri_ready_i;
   logic int_stable_i, irq_pending_i, wdt_timeout_i, cpu_clk_en_o, periph_clk_en_o;
   logic pri_osc_en_o, cpu_ready_o, wdt_reset_o;
   logic [1:0] sys_clk_src_o;
   logic [31:0] hrdata, hr_s, rd, hw;
   int n_fail = 0;
   int check_count = 0;
   int seed = 27;
   int n;
   int sec_m = 0;
   int modes [6] = '{1, 2, 4, 5, 7, 0};
   always #25 clk_i = !clk_i;
   power_mode_clock_switch #(.SWITCH_TICKS(8)) i_dut (.clk_i, .sys_rst_i, .hsel, .haddr,
      .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
      .hrdata, .sleep_i, .pri_tick_i, .sec_tick_i, .int_tick_i, .pri_ready_i, .int_stable_i,
      .irq_pending_i, .wdt_timeout_i, .cpu_clk_en_o, .periph_clk_en_o, .sys_clk_src_o,
      .pri_osc_en_o, .cpu_ready_o, .wdt_reset_o);
   cpu_osc_model i_mdl (.clk_i, .pri_osc_en_i(pri_osc_en_o), .cpu_ready_i(cpu_ready_o),
      .sleep_req_i(sleep_req), .irq_req_i(irq_req), .wdt_req_i(wdt_req), .sleep_o(sleep_i),
      .pri_tick_o(pri_tick_i), .sec_tick_o(sec_tick_i), .int_tick_o(int_tick_i),
      .pri_ready_o(pri_ready_i), .int_stable_o(int_stable_i), .irq_o(irq_pending_i),
      .wdt_o(wdt_timeout_i));
   // read data is captured as it stood before the sampling edge
   always @(posedge clk_i) begin
      hr_s <= hrdata;
      if (wdt_reset_o === 1'b1) wdt_seen <= 1'b1;
   end
   task report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one single ahb-lite transfer; read data lands in rd
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_i);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge clk_i);
      while (hreadyout !== 1'b1) @(posedge clk_i);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk_i);
      while (hreadyout !== 1'b1) @(posedge clk_i);
      #1 rd = hr_s;
   endtask
   task pulse_sleep;
      @(posedge clk_i);
      sleep_req <= 1'b1;
      @(posedge clk_i);
      while (sleep_i !== 1'b1) @(posedge clk_i);
      sleep_req <= 1'b0;
   endtask
   // bounded wait for a source and gate combination
   task wait_st(input logic [1:0] s, input logic c, input logic p);
      n = 0;
      while (n < 3000 && {sys_clk_src_o, cpu_clk_en_o, periph_clk_en_o} !== {s, c, p}) begin
         @(posedge clk_i);
         #1 n++;
      end
      chk("settle", 1, n < 3000);
   endtask
   // enter one mode, check it, wake back to primary run
   task run_mode(input int g, input int s);
      logic [1:0] es;
      logic cpu;
      es = s == 0 ? (g != 0 ? 2'h1 : 2'h0) : (s == 1 ? 2'h2 : 2'h3);
      cpu = g == 0 && s != 0;
      ahb(1, 32'h0, 32'(g * 128 + s));
      chk("src before sleep", 2'h1, sys_clk_src_o);
      pulse_sleep;
      @(posedge clk_i);
      #1 chk("cpu halt", 0, cpu_clk_en_o);
      wait_st(es, cpu, g != 0 || s != 0);
      ahb(0, 32'h8, 32'h0);
      chk("mode", (g == 0 && s == 0 ? 7 : g * 4 + (s > 1 ? 2 : s)) + (cpu ? 0 : 32'h20), rd);
      ahb(0, 32'h0, 32'h0);
      chk("ctrl flags", 32'(g * 128 + s + (es == 1 ? 8 : 0)), rd);
      ahb(0, 32'h4, 32'h0);
      chk("sec flag", 32'(sec_m * 8 + (es == 2 ? 64 : 0)), rd);
      @(posedge clk_i);
      if (es == 2'h0) wdt_req <= 1'b1;
      else irq_req <= 1'b1;
      n = 0;
      while (n < 3000 && cpu_clk_en_o !== 1'b1) begin
         @(posedge clk_i);
         #1 n++;
      end
      if (!cpu) chk("wake delay", 1, n >= 200);
      chk("wake source", es == 2'h0 ? 2'h1 : es, sys_clk_src_o);
      wait_st(2'h1, 1'b1, 1'b1);
      @(posedge clk_i);
      irq_req <= 1'b0;
      wdt_req <= 1'b0;
      ahb(0, 32'h8, 32'h0);
      chk("back to primary", 0, rd);
      ahb(0, 32'h0, 32'h0);
      chk("bits kept", 32'(g * 128 + s + 8), rd);
      chk("no wdt reset", 0, wdt_seen);
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      while (pri_ready_i !== 1'b1) @(posedge clk_i);
      repeat (4) @(posedge clk_i);
      ahb(0, 32'h0, 32'h0);
      chk("ctrl reset", 32'h8, rd);
      ahb(0, 32'h4, 32'h0);
      chk("sec reset", 0, rd);
      ahb(0, 32'hc, 32'h0);
      chk("cfg reset", 0, rd);
      ahb(1, 32'h8, 32'h77);
      ahb(0, 32'h8, 32'h0);
      chk("status read only", 0, rd);
      // random gate and frequency bits read back; select stays primary
      repeat (4) begin
         hw = $random(seed) & 32'hf0;
         ahb(1, 32'h0, hw);
         ahb(0, 32'h0, 32'h0);
         chk("ctrl rw", hw | 32'h8, rd & 32'hfb);
      end
      ahb(1, 32'h0, 32'h1);
      pulse_sleep;
      repeat (20) @(posedge clk_i);
      #1 chk("sec select ignored", 3'h3, {sys_clk_src_o, cpu_clk_en_o});
      ahb(1, 32'h4, 32'h8);
      sec_m = 1;
      foreach (modes[i]) run_mode(modes[i] / 4, modes[i] % 4);
      // fast start from sleep with the internal block as primary
      ahb(1, 32'hc, 32'h5);
      ahb(0, 32'hc, 32'h0);
      chk("cfg rw", 32'h5, rd);
      ahb(1, 32'h0, 32'h70);
      ahb(0, 32'h0, 32'h0);
      chk("both flags", 32'h7c, rd);
      pulse_sleep;
      wait_st(2'h0, 1'b0, 1'b0);
      @(posedge clk_i);
      wdt_req <= 1'b1;
      n = 0;
      while (n < 3000 && cpu_clk_en_o !== 1'b1) begin
         @(posedge clk_i);
         #1 n++;
      end
      chk("fast wake delay", 1, n >= 200);
      chk("fast start src", 2'h3, sys_clk_src_o);
      ahb(0, 32'h0, 32'h0);
      chk("internal flag", 32'h74, rd);
      ahb(0, 32'h8, 32'h0);
      chk("fast start mode", 32'h42, rd);
      wait_st(2'h1, 1'b1, 1'b1);
      @(posedge clk_i);
      wdt_req <= 1'b0;
      ahb(0, 32'h0, 32'h0);
      chk("back on primary", 32'h7c, rd);
      @(posedge clk_i);
      wdt_req <= 1'b1;
      repeat (8) @(posedge clk_i);
      wdt_req <= 1'b0;
      chk("wdt reset in run", 1, wdt_seen);
      report_and_stop;
   end
   initial begin
      #2000000;
      n_fail++;
      report_and_stop;
   end
endmodule // power_mode_clock_switch_tb
